// *** design/liu_regs_map.svh ***
// register offsets, field positions and reset values of the irq/pulse bank
`ifndef LIU_REGS_MAP_SVH
`define LIU_REGS_MAP_SVH

// register indices, byte address is four times the index
`define IRQ_FLAGS_IDX 8'h06
`define CABLE_LOSS_IDX 8'h07
`define SEG_ONE_IDX 8'h08
`define IRQ_ENABLE_IDX 8'h10
`define PULSE_CFG_IDX 8'h11

// apb byte addresses
`define IRQ_FLAGS_ADDR 12'h018
`define CABLE_LOSS_ADDR 12'h01C
`define SEG_ONE_ADDR 12'h020
`define IRQ_ENABLE_ADDR 12'h040
`define PULSE_CFG_ADDR 12'h044

// field layout
`define FLAG_COUNT 7
`define FLAG_MSB 6
`define FIFO_FLAG_BIT 5
`define ATTEN_MSB 5
`define SEG_AMP_MSB 6
`define SEG_SIGN_BIT 6
`define SEG_MAG_MSB 5
`define ARB_MODE_BIT 0
`define LAST_SEGMENT 3'h7
`define FIRST_SEGMENT 3'h0

// reset values
`define IRQ_FLAGS_RST 7'h00
`define IRQ_ENABLE_RST 7'h00
`define CABLE_LOSS_RST 6'h00
`define SEG_ONE_RST 7'h00
`define PULSE_CFG_RST 1'h0

// jitter fifo near-limit window, in bit positions
`define FIFO_NEAR_GAP 6'h03
`define FIFO_PTR_MSB 5

`endif

// *** design/liu_regs_pkg.sv ***
// types shared by the irq status, cable loss and pulse segment bank
package liu_regs_pkg;

	// live indications from the receive and transmit monitors
	typedef struct packed {
		logic driver_fault_indication;
		logic code_violation_indication;
		logic loop_code_indication;
		logic all_ones_alarm_indication;
		logic signal_loss_indication;
		logic pattern_sync_indication;
	} monitor_s;

	// drive toward the transmit pulse shaper
	typedef struct packed {
		logic active;
		logic [2:0] index;
		logic negative;
		logic [5:0] magnitude;
	} seg_drive_s;

	// segment sequencer states
	typedef enum logic [1:0] {
		SEG_WAIT = 2'b01,
		SEG_RUN = 2'b10
	} seg_state_e;

endpackage : liu_regs_pkg

// *** design/liu_irq_status_cable_loss_pulse_regs.sv ***
// apb bank: change flags, cable loss estimate, first pulse segment amplitude
`timescale 1ns/100ps
`include "liu_regs_map.svh"

module liu_irq_status_cable_loss_pulse_regs
	import liu_regs_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire monitor_s mon_in,
	input wire logic [5:0] jitter_wr_ptr,
	input wire logic [5:0] jitter_rd_ptr,
	input wire logic jitter_depth_64,
	input wire logic [5:0] eq_attenuation,
	input wire logic mclk_period_start,
	input wire logic seg_tick,
	input wire logic [6:0] other_segment_amplitude,
	output logic irq,
	output seg_drive_s seg_drive
);

	// register state
	logic [`FLAG_MSB:0] change_ff;
	logic [`FLAG_MSB:0] prev_ff;
	logic [`FLAG_MSB:0] enable_ff;
	logic [`ATTEN_MSB:0] atten_ff;
	logic [`SEG_AMP_MSB:0] seg_one_ff;
	logic arb_mode_ff;
	logic [31:0] rd_data_ff;
	logic err_ff;
	logic [`FLAG_MSB:0] snap_ff;
	seg_state_e seg_state_ff;
	seg_state_e nxt_seg_state;
	logic [2:0] seg_index_ff;
	logic [2:0] nxt_seg_index;
	seg_drive_s drive_ff;
	seg_drive_s nxt_drive;

	// bus phase decode
	wire setup_phase;
	wire access_done;
	wire wr_done;
	wire rd_done;
	wire hit_flags;
	wire hit_cable;
	wire hit_seg_one;
	wire hit_enable;
	wire hit_cfg;
	wire hit_any;
	wire wr_flags;
	wire wr_enable;
	wire wr_seg_one;
	wire wr_cfg;

	// zero wait states; pready follows ce so a frozen block stalls the bus
	assign pready = ce;
	assign setup_phase = psel & ~penable & ce;
	assign access_done = psel & penable & ce;
	assign wr_done = access_done & pwrite;
	assign rd_done = access_done & ~pwrite;

	// address decode on full byte address
	assign hit_flags = (paddr == `IRQ_FLAGS_ADDR);
	assign hit_cable = (paddr == `CABLE_LOSS_ADDR);
	assign hit_seg_one = (paddr == `SEG_ONE_ADDR);
	assign hit_enable = (paddr == `IRQ_ENABLE_ADDR);
	assign hit_cfg = (paddr == `PULSE_CFG_ADDR);
	assign hit_any = hit_flags | hit_cable | hit_seg_one | hit_enable | hit_cfg;

	// write strobes, taken at the completing access edge only
	assign wr_flags = wr_done & hit_flags;
	assign wr_enable = wr_done & hit_enable;
	assign wr_seg_one = wr_done & hit_seg_one;
	assign wr_cfg = wr_done & hit_cfg;

	// jitter fifo near-limit: pointers within three positions either way
	// either pointer may lead, so both distances are tested
	wire [5:0] ptr_gap_raw;
	wire [5:0] ptr_gap;
	wire [5:0] ptr_gap_back;
	wire fifo_near_limit;

	assign ptr_gap_raw = jitter_wr_ptr - jitter_rd_ptr;
	// 32-deep mode wraps at 32, so the top pointer bit is ignored there
	assign ptr_gap = jitter_depth_64 ? ptr_gap_raw :
		{1'b0, ptr_gap_raw[`FIFO_PTR_MSB-1:0]};
	assign ptr_gap_back = jitter_depth_64 ? (6'h00 - ptr_gap) :
		{1'b0, 5'(5'h00 - ptr_gap[`FIFO_PTR_MSB-1:0])};
	assign fifo_near_limit = (ptr_gap <= `FIFO_NEAR_GAP) |
		(ptr_gap_back <= `FIFO_NEAR_GAP);

	// live indications in flag bit order
	wire [`FLAG_MSB:0] live;

	assign live = {
		mon_in.driver_fault_indication,
		fifo_near_limit,
		mon_in.code_violation_indication,
		mon_in.loop_code_indication,
		mon_in.all_ones_alarm_indication,
		mon_in.signal_loss_indication,
		mon_in.pattern_sync_indication
	};

	// per-bit change detection and sticky flags
	// prev_ff resets low, so a level already high at release sets its flag
	wire [`FLAG_MSB:0] changed;
	wire [`FLAG_MSB:0] flag_clr;
	wire [`FLAG_MSB:0] nxt_change;

	genvar gi;
	generate
		for (gi = 0; gi < `FLAG_COUNT; gi = gi + 1)
		begin : g_flag
			// any edge, rising or falling, counts as a change
			assign changed[gi] = live[gi] ^ prev_ff[gi];
			// read clears only what the host actually saw; write one also clears
			assign flag_clr[gi] = (rd_done & snap_ff[gi]) |
				(wr_flags & pwdata[gi]);
			// a change in the clearing cycle survives: set wins
			assign nxt_change[gi] = changed[gi] |
				(change_ff[gi] & ~flag_clr[gi]);

			always_ff @(posedge core_clk or negedge rst_b)
			begin
				if (!rst_b)
				begin
					change_ff[gi] <= 1'b0;
					prev_ff[gi] <= 1'b0;
				end
				else if (ce)
				begin
					change_ff[gi] <= nxt_change[gi];
					prev_ff[gi] <= live[gi];
				end
			end
		end
	endgenerate

	// level interrupt from enabled flags
	// stays high until the host clears or masks every enabled flag
	assign irq = |(change_ff & enable_ff);

	// irq enable mask, same layout as the flags; strobe already holds ce
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			enable_ff <= `IRQ_ENABLE_RST;
		else if (wr_enable)
			enable_ff <= pwdata[`FLAG_MSB:0];
	end

	// segment one amplitude; bit 7 is reserved and not stored
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			seg_one_ff <= `SEG_ONE_RST;
		else if (wr_seg_one)
			seg_one_ff <= pwdata[`SEG_AMP_MSB:0];
	end

	// pulse configuration: only the arbitrary mode bit lives here
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			arb_mode_ff <= `PULSE_CFG_RST;
		else if (wr_cfg)
			arb_mode_ff <= pwdata[`ARB_MODE_BIT];
	end

	// equalizer estimate sampled every cycle with ce high; read-only to the host
	// a host write here is dropped quietly, without a bus error
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			atten_ff <= `CABLE_LOSS_RST;
		else if (ce)
			atten_ff <= eq_attenuation;
	end

	// one named word per register; reserved and upper bits read as zero
	wire [31:0] flags_word;
	wire [31:0] cable_word;
	wire [31:0] seg_one_word;
	wire [31:0] enable_word;
	wire [31:0] cfg_word;
	wire [31:0] rd_mux;

	assign flags_word = {25'h0, change_ff};
	assign cable_word = {26'h0, atten_ff};
	assign seg_one_word = {25'h0, seg_one_ff};
	assign enable_word = {25'h0, enable_ff};
	assign cfg_word = {31'h0, arb_mode_ff};

	// read mux; an unmapped address reads as zero
	assign rd_mux =
		hit_flags ? flags_word :
		hit_cable ? cable_word :
		hit_seg_one ? seg_one_word :
		hit_enable ? enable_word :
		hit_cfg ? cfg_word :
		32'h0;

	// read data and error captured at setup so prdata comes from a flop
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rd_data_ff <= 32'h0;
			err_ff <= 1'b0;
		end
		else if (setup_phase)
		begin
			rd_data_ff <= rd_mux;
			err_ff <= ~hit_any;
		end
	end

	// remember which flags the host is about to read, so a flag that
	// sets between setup and access is not lost at the clearing edge
	wire [`FLAG_MSB:0] nxt_snap;

	assign nxt_snap = (hit_flags & ~pwrite) ? change_ff : `IRQ_FLAGS_RST;

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			snap_ff <= `IRQ_FLAGS_RST;
		else if (setup_phase)
			snap_ff <= nxt_snap;
	end

	assign prdata = rd_data_ff;
	assign pslverr = err_ff;

	// segment sequencer: eight ticks per master period
	// the tick source divides the period; the sequencer only counts
	always_comb
	begin
		nxt_seg_state = seg_state_ff;
		nxt_seg_index = seg_index_ff;
		unique case (seg_state_ff)
			SEG_WAIT:
			begin
				if (mclk_period_start)
				begin
					nxt_seg_state = SEG_RUN;
					nxt_seg_index = `FIRST_SEGMENT;
				end
			end
			SEG_RUN:
			begin
				// a new period always restarts at segment one
				if (mclk_period_start)
					nxt_seg_index = `FIRST_SEGMENT;
				else if (seg_tick)
				begin
					if (seg_index_ff == `LAST_SEGMENT)
						nxt_seg_state = SEG_WAIT;
					else
						nxt_seg_index = 3'(seg_index_ff + 3'h1);
				end
			end
			default:
			begin
				nxt_seg_state = SEG_WAIT;
				nxt_seg_index = `FIRST_SEGMENT;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			seg_state_ff <= SEG_WAIT;
			seg_index_ff <= `FIRST_SEGMENT;
		end
		else if (ce)
		begin
			seg_state_ff <= nxt_seg_state;
			seg_index_ff <= nxt_seg_index;
		end
	end

	// amplitude for the current segment, split into sign and magnitude
	wire [`SEG_AMP_MSB:0] cur_amp;
	wire arb_run;

	assign arb_run = arb_mode_ff & (nxt_seg_state == SEG_RUN);
	assign cur_amp = (nxt_seg_index == `FIRST_SEGMENT) ? seg_one_ff :
		other_segment_amplitude;

	// sign-magnitude split; outside arbitrary mode the shaper sees zero,
	// so a stale amplitude never leaks into a fixed pulse shape
	wire cur_sign;
	wire [`SEG_MAG_MSB:0] cur_mag;

	assign cur_sign = arb_run & cur_amp[`SEG_SIGN_BIT];
	assign cur_mag = arb_run ? cur_amp[`SEG_MAG_MSB:0] : 6'h00;

	always_comb
	begin
		nxt_drive.active = arb_run;
		nxt_drive.index = nxt_seg_index;
		nxt_drive.negative = cur_sign;
		nxt_drive.magnitude = cur_mag;
	end

	// registered drive toward the pulse shaper
	// a flop here keeps decode glitches away from the line driver
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			drive_ff <= '0;
		else if (ce)
			drive_ff <= nxt_drive;
	end

	assign seg_drive = drive_ff;

endmodule : liu_irq_status_cable_loss_pulse_regs

// *** tb/liu_regs_monitor.sv ***
// assertions on the ports of the irq, cable loss and pulse bank
`timescale 1ns/100ps
module liu_regs_monitor
	import liu_regs_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire monitor_s mon_in,
	input wire logic [5:0] jitter_wr_ptr,
	input wire logic [5:0] jitter_rd_ptr,
	input wire logic jitter_depth_64,
	input wire logic [5:0] eq_attenuation,
	input wire logic mclk_period_start,
	input wire logic irq,
	input wire seg_drive_s seg_drive
);
	logic [6:0] en_ff;
	logic [6:0] seg_ff;
	logic arb_ff;
	// bus phases, fifo window and flag enables in monitor order
	wire wr_w = psel && penable && pwrite && ce;
	wire su_w = psel && !penable && ce;
	wire [5:0] msk_w = jitter_depth_64 ? 6'h3F : 6'h1F;
	wire [5:0] dwr_w = (jitter_wr_ptr - jitter_rd_ptr) & msk_w;
	wire [5:0] drw_w = (jitter_rd_ptr - jitter_wr_ptr) & msk_w;
	wire near_w = dwr_w <= 6'h03 || drw_w <= 6'h03;
	wire [5:0] men_w = {en_ff[6], en_ff[4:0]};
	wire idle_w = !arb_ff && ce;
	wire map_w = paddr inside {12'h018, 12'h01C, 12'h020, 12'h040, 12'h044};

	// shadow of host-written registers, so checks need no body access
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			en_ff <= 7'h00;
			seg_ff <= 7'h00;
			arb_ff <= 1'h0;
		end
		else if (wr_w)
		begin
			if (paddr == 12'h040)
				en_ff <= pwdata[6:0];
			if (paddr == 12'h020)
				seg_ff <= pwdata[6:0];
			if (paddr == 12'h044)
				arb_ff <= pwdata[0];
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	chk_mon_irq: assert property (
		ce && $past(ce) && $past(rst_b) && |((mon_in ^ $past(mon_in)) & men_w)
		|=> irq) else $error("monitor change gave no irq");
	chk_fifo_irq: assert property (
		ce && $past(ce) && $past(rst_b) && $changed(near_w) && en_ff[5]
		|=> irq) else $error("fifo limit change gave no irq");
	chk_irq_gate: assert property (irq |-> en_ff != 7'h00)
		else $error("irq with every source disabled");
	chk_flag_top: assert property (
		su_w && paddr == 12'h018 |=> prdata[31:7] == 25'h0)
		else $error("flag word upper bits not zero");
	chk_cable_word: assert property (
		su_w && paddr == 12'h01C && $past(ce) && $past(rst_b)
		&& $stable(eq_attenuation) |=> prdata == {26'h0, $past(eq_attenuation)})
		else $error("cable word differs from estimate");
	chk_seg_read: assert property (
		su_w && paddr == 12'h020 |=> prdata == {25'h0, seg_ff})
		else $error("segment one readback wrong");
	chk_seg_start: assert property (
		mclk_period_start && ce && arb_ff && !wr_w
		|=> seg_drive == {1'b1, 3'h0, seg_ff})
		else $error("first segment drive wrong");
	chk_seg_idle: assert property (
		idle_w && $past(idle_w) && $past(idle_w, 2)
		|-> !seg_drive.active && seg_drive.magnitude == 6'h00)
		else $error("pulse drive outside arbitrary mode");
	chk_bad_addr: assert property (su_w && !map_w |=> pslverr)
		else $error("unmapped address without error");

	cov_flag_read: cover property (su_w && paddr == 12'h018 ##1 prdata != 0);
	cov_seg_run: cover property (seg_drive.active && seg_drive.index == 3'h7);
	cov_bus_err: cover property (pslverr);
endmodule : liu_regs_monitor

bind liu_irq_status_cable_loss_pulse_regs liu_regs_monitor mon_u (.core_clk,
	.rst_b, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pslverr,
	.mon_in, .jitter_wr_ptr, .jitter_rd_ptr, .jitter_depth_64, .eq_attenuation,
	.mclk_period_start, .irq, .seg_drive);

// *** tb/tb_top.sv ***
// self-checking bench for the irq, cable loss and pulse segment bank
`timescale 1ns/100ps
module tb_top
	import liu_regs_pkg::*;
;
	logic core_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
	logic ce = 1, depth_64 = 1;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, irq, mclk_period_start = 0, seg_tick = 0;
	monitor_s mon_in = '0;
	logic [5:0] wr_p = 6'h0B, rd_p = 6'h20, eq_att = 6'h00;
	logic [6:0] oth = 7'h00;
	seg_drive_s seg_drive;
	logic [32:0] exp_q[$];
	logic [15:0] seed = 16'h990A;
	int fails = 0, tests_run = 0, cyc = 0;

	liu_irq_status_cable_loss_pulse_regs dut_u (.core_clk, .rst_b,
		.ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .mon_in, .jitter_wr_ptr(wr_p), .jitter_rd_ptr(rd_p),
		.jitter_depth_64(depth_64), .eq_attenuation(eq_att), .mclk_period_start,
		.seg_tick, .other_segment_amplitude(oth), .irq, .seg_drive);

	initial
		forever #12.5 core_clk = ~core_clk;

	task chk(input string n, input logic [32:0] s, input logic [32:0] e);
		tests_run++;
		if (s !== e)
		begin
			fails++;
			$display("BAD %s exp %h seen %h", n, e, s);
		end
	endtask : chk

	task stop_test();
		$display("checks %0d fails %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : stop_test

	// completed reads are matched to the oldest note; hangs end the run
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc > 5000)
		begin
			fails++;
			stop_test();
		end
		else if (psel && penable && pready === 1'b1 && !pwrite)
			chk("read", {pslverr, prdata}, exp_q.pop_front());
	end

	function logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	task w(input int n);
		repeat (n) @(posedge core_clk);
	endtask : w

	// one apb transfer; no wait count assumed, pready ends the access
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1;
		do
			@(posedge core_clk);
		while (pready !== 1'b1);
		psel <= 0;
		penable <= 0;
	endtask : apb

	task rd(input logic [11:0] a, input logic [32:0] e);
		exp_q.push_back(e);
		apb(0, a, 0);
	endtask : rd

	initial
	begin
		logic [32:0] e;
		w(3);
		rst_b <= 1;
		rd(12'h018, 0);
		rd(12'h020, 0);
		rd(12'h0FC, 33'h100000000);
		$display("test reset done");
		// estimate follows the equalizer; writes leave it alone
		repeat (4)
		begin
			seed = lfsr(seed);
			eq_att <= seed[5:0];
			apb(1, 12'h01C, 32'hFFFFFFFF);
			rd(12'h01C, {27'h0, seed[5:0]});
		end
		$display("test cable done");
		// six monitors, then fifo gap 3 (near) and gap 4 (far)
		apb(1, 12'h040, 32'h7F);
		for (int i = 0; i < 8; i++)
		begin
			if (i < 6)
				mon_in <= mon_in ^ (6'h01 << i);
			else
				rd_p <= (i == 6) ? 6'h08 : 6'h07;
			w(2);
			chk("irq", irq, 1);
			e = 33'h1 << (i == 5 ? 6 : i > 5 ? 5 : i);
			rd(12'h018, e);
			rd(12'h018, 0);
			w(1);
			chk("irq", irq, 0);
		end
		// masked source still flags but keeps irq low
		apb(1, 12'h040, 0);
		mon_in <= mon_in ^ 6'h20;
		w(2);
		chk("irq", irq, 0);
		rd(12'h018, 33'h40);
		// frozen block holds its flags and stalls the bus
		apb(1, 12'h040, 32'h7F);
		rd(12'h040, 33'h7F);
		ce <= 0;
		mon_in <= mon_in ^ 6'h01;
		w(3);
		chk("pready", pready, 0);
		chk("irq", irq, 0);
		ce <= 1;
		w(2);
		chk("irq", irq, 1);
		// write one clears, then 32-deep fifo ignores the top pointer bit
		apb(1, 12'h018, 32'h01);
		rd(12'h018, 0);
		depth_64 <= 0;
		rd_p <= 6'h28;
		w(2);
		chk("irq", irq, 1);
		rd(12'h018, 33'h20);
		$display("test flags done");
		// segment one amplitude then a full eight-segment period
		seed = lfsr(seed);
		oth <= seed[15:9];
		apb(1, 12'h020, {25'h1FFFFFF, seed[6:0]});
		rd(12'h020, seed[6:0]);
		apb(1, 12'h044, 1);
		for (int j = 0; j < 9; j++)
		begin
			mclk_period_start <= j == 0;
			seg_tick <= j != 0;
			w(1);
			mclk_period_start <= 0;
			seg_tick <= 0;
			w(2);
			e = {1'b1, 3'(j), j ? oth : seed[6:0]};
			if (j == 8)
				chk("seg", seg_drive.active, 0);
			else
				chk("seg", seg_drive, e);
		end
		apb(1, 12'h044, 0);
		mclk_period_start <= 1;
		w(1);
		mclk_period_start <= 0;
		w(3);
		chk("seg", {seg_drive.active, seg_drive.magnitude}, 0);
		$display("test pulse done");
		stop_test();
	end
endmodule : tb_top
